/* File: rtl/tw_pkg.sv */
`default_nettype none
package tw_pkg;

  // Bus geometry and register indices; the byte address is four times the index.
  localparam int          ADDR_W              = 12;
  localparam logic [9:0]  IDX_OUTPUT_MODE_CTRL   = 10'h080;
  localparam logic [9:0]  IDX_CLOCK_CAPTURE_CTRL = 10'h081;
  localparam logic [9:0]  IDX_COUNT_VALUE     = 10'h082;
  localparam logic [9:0]  IDX_COMPARE_A       = 10'h083;
  localparam logic [9:0]  IDX_COMPARE_B       = 10'h084;
  localparam logic [9:0]  IDX_CAPTURE         = 10'h085;
  localparam logic [9:0]  IDX_EVENT_FLAGS     = 10'h086;
  localparam logic [9:0]  IDX_PIN_DIRECTION   = 10'h087;

  // Field positions in the two control registers.
  localparam int          CHA_MODE_POS        = 6;
  localparam int          CHB_MODE_POS        = 4;
  localparam int          WSEL_LO_POS         = 0;
  localparam int          FILTER_EN_POS       = 7;
  localparam int          EDGE_SEL_POS        = 6;
  localparam int          WSEL_HI_POS         = 3;
  localparam int          CLK_SEL_POS         = 0;
  localparam logic [7:0]  OUTPUT_MODE_WMASK   = 8'hf3;
  localparam logic [7:0]  CLOCK_CAPTURE_WMASK = 8'hdf;
  localparam logic [7:0]  CTRL_RESET          = 8'h00;

  // Event flag bits.
  localparam int          FLG_OVERFLOW        = 0;
  localparam int          FLG_MATCH_A         = 1;
  localparam int          FLG_MATCH_B         = 2;
  localparam int          FLG_CAPTURE         = 3;

  // Count limits.
  localparam logic [15:0] CNT_MAX             = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM          = 16'h0000;
  localparam logic [15:0] TOP_8BIT            = 16'h00ff;
  localparam logic [15:0] TOP_9BIT            = 16'h01ff;
  localparam logic [15:0] TOP_10BIT           = 16'h03ff;

  // Waveform select codes.
  localparam logic [3:0]  WM_NORMAL    = 4'h0;
  localparam logic [3:0]  WM_PC_8      = 4'h1;
  localparam logic [3:0]  WM_PC_9      = 4'h2;
  localparam logic [3:0]  WM_PC_10     = 4'h3;
  localparam logic [3:0]  WM_CTC_CMPA  = 4'h4;
  localparam logic [3:0]  WM_FAST_8    = 4'h5;
  localparam logic [3:0]  WM_FAST_9    = 4'h6;
  localparam logic [3:0]  WM_FAST_10   = 4'h7;
  localparam logic [3:0]  WM_PFC_CAPT  = 4'h8;
  localparam logic [3:0]  WM_PFC_CMPA  = 4'h9;
  localparam logic [3:0]  WM_PC_CAPT   = 4'ha;
  localparam logic [3:0]  WM_PC_CMPA   = 4'hb;
  localparam logic [3:0]  WM_CTC_CAPT  = 4'hc;
  localparam logic [3:0]  WM_RESERVED  = 4'hd;
  localparam logic [3:0]  WM_FAST_CAPT = 4'he;
  localparam logic [3:0]  WM_FAST_CMPA = 4'hf;

  // Clock source select codes and prescaler.
  localparam logic [2:0]  CS_STOP      = 3'h0;
  localparam logic [2:0]  CS_DIV1      = 3'h1;
  localparam logic [2:0]  CS_DIV8      = 3'h2;
  localparam logic [2:0]  CS_DIV64     = 3'h3;
  localparam logic [2:0]  CS_DIV256    = 3'h4;
  localparam logic [2:0]  CS_DIV1024   = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL  = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE  = 3'h7;
  localparam int          PRESC_W      = 10;
  localparam logic [9:0]  DIV8_LAST    = 10'h007;
  localparam logic [9:0]  DIV64_LAST   = 10'h03f;
  localparam logic [9:0]  DIV256_LAST  = 10'h0ff;
  localparam logic [9:0]  DIV1024_LAST = 10'h3ff;

  localparam int          FILTER_DEPTH = 4;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [4:0] {
    CLS_NORMAL = 5'b00001,
    CLS_CTC    = 5'b00010,
    CLS_PC     = 5'b00100,
    CLS_PFC    = 5'b01000,
    CLS_FAST   = 5'b10000
  } tw_mode_class_t;

endpackage : tw_pkg
`default_nettype wire

/* File: rtl/tw_timer16_waveform_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tw_timer16_waveform_control #(
  parameter int ADDR_W     = tw_pkg::ADDR_W,
  parameter int FILTER_LEN = tw_pkg::FILTER_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic              capture_pin,
  input  wire logic              external_count_pin,
  output logic                   wave_out_a,
  output logic                   wave_out_a_en,
  output logic                   wave_out_b,
  output logic                   wave_out_b_en
);

  typedef struct packed {
    logic [7:0]                output_mode_ctrl;
    logic [7:0]                clock_capture_ctrl;
    logic [1:0]                pin_direction;
    logic [15:0]               count_value;
    logic [15:0]               buffer_a;
    logic [15:0]               buffer_b;
    logic [15:0]               compare_value_a;
    logic [15:0]               compare_value_b;
    logic [15:0]               capture_value;
    logic                      count_down;
    logic [3:0]                flags;
    logic [tw_pkg::PRESC_W-1:0] presc;
    logic [1:0]                capSync;
    logic [1:0]                extSync;
    logic                      extPrev;
    logic [FILTER_LEN-1:0]     capHist;
    logic                      capFilt;
    logic                      capPrev;
    logic                      waveA;
    logic                      waveB;
    logic                      waveAEn;
    logic                      waveBEn;
    logic                      awReady;
    logic                      wReady;
    logic                      awHeld;
    logic                      wHeld;
    logic [ADDR_W-1:0]         awAddr;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      arReady;
    logic                      rValid;
    logic [31:0]               rData;
    logic [1:0]                rResp;
  } tw_state_t;

  tw_state_t st;
  tw_state_t next_st;

  function automatic tw_pkg::tw_mode_class_t modeClass(input logic [3:0] m);
    case (m)
      tw_pkg::WM_PC_8, tw_pkg::WM_PC_9, tw_pkg::WM_PC_10,
      tw_pkg::WM_PC_CAPT, tw_pkg::WM_PC_CMPA: modeClass = tw_pkg::CLS_PC;
      tw_pkg::WM_PFC_CAPT, tw_pkg::WM_PFC_CMPA: modeClass = tw_pkg::CLS_PFC;
      tw_pkg::WM_FAST_8, tw_pkg::WM_FAST_9, tw_pkg::WM_FAST_10,
      tw_pkg::WM_FAST_CAPT, tw_pkg::WM_FAST_CMPA: modeClass = tw_pkg::CLS_FAST;
      tw_pkg::WM_CTC_CMPA, tw_pkg::WM_CTC_CAPT: modeClass = tw_pkg::CLS_CTC;
      default: modeClass = tw_pkg::CLS_NORMAL;
    endcase
  endfunction : modeClass

  function automatic logic topFromCapture(input logic [3:0] m);
    topFromCapture = (m == tw_pkg::WM_PFC_CAPT) || (m == tw_pkg::WM_PC_CAPT) ||
                     (m == tw_pkg::WM_CTC_CAPT) || (m == tw_pkg::WM_FAST_CAPT);
  endfunction : topFromCapture

  function automatic logic [15:0] topOf(input logic [3:0]  m,
                                        input logic [15:0] cmpA,
                                        input logic [15:0] capt);
    case (m)
      tw_pkg::WM_PC_8, tw_pkg::WM_FAST_8: topOf = tw_pkg::TOP_8BIT;
      tw_pkg::WM_PC_9, tw_pkg::WM_FAST_9: topOf = tw_pkg::TOP_9BIT;
      tw_pkg::WM_PC_10, tw_pkg::WM_FAST_10: topOf = tw_pkg::TOP_10BIT;
      tw_pkg::WM_CTC_CMPA, tw_pkg::WM_PFC_CMPA,
      tw_pkg::WM_PC_CMPA, tw_pkg::WM_FAST_CMPA: topOf = cmpA;
      tw_pkg::WM_PFC_CAPT, tw_pkg::WM_PC_CAPT,
      tw_pkg::WM_CTC_CAPT, tw_pkg::WM_FAST_CAPT: topOf = capt;
      default: topOf = tw_pkg::CNT_MAX;
    endcase
  endfunction : topOf

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  // Next level of one waveform output for one tick; isA selects channel A rules.
  function automatic logic waveNext(input tw_pkg::tw_mode_class_t cls,
                                    input logic [1:0] com,
                                    input logic       isA,
                                    input logic [3:0] m,
                                    input logic       match,
                                    input logic       cmpIsTop,
                                    input logic       atTop,
                                    input logic       down,
                                    input logic       cur);
    waveNext = cur;
    case (cls)
      tw_pkg::CLS_FAST: begin
        if (com == 2'b01 && isA && match &&
            (m == tw_pkg::WM_FAST_CAPT || m == tw_pkg::WM_FAST_CMPA)) begin
          waveNext = ~cur;
        end
        if (com[1] && match && !cmpIsTop) begin
          waveNext = com[0];
        end
        if (com[1] && atTop) begin
          waveNext = ~com[0];
        end
      end
      tw_pkg::CLS_PC, tw_pkg::CLS_PFC: begin
        if (com == 2'b01 && isA && match &&
            (m == tw_pkg::WM_PFC_CMPA || m == tw_pkg::WM_PC_CMPA)) begin
          waveNext = ~cur;
        end
        if (com[1] && match) begin
          waveNext = com[0] ^ down;
        end
      end
      default: begin
        if (match) begin
          case (com)
            2'b01: waveNext = ~cur;
            2'b10: waveNext = 1'b0;
            2'b11: waveNext = 1'b1;
            default: waveNext = cur;
          endcase
        end
      end
    endcase
  endfunction : waveNext

  logic [3:0]             wsel;
  tw_pkg::tw_mode_class_t cls;
  logic [15:0]            top;
  logic [1:0]             comA;
  logic [1:0]             comB;
  logic [2:0]             clkSel;
  logic                   tick;
  logic                   atTop;
  logic                   atBottom;
  logic                   matchA;
  logic                   matchB;
  logic                   capEdge;
  logic                   capTop;
  logic                   doWrite;
  logic                   awHs;
  logic                   wHs;
  logic                   arHs;
  logic [9:0]             wIdx;
  logic [9:0]             rIdx;
  logic [3:0]             flagSet;
  logic [3:0]             flagClr;

  always_comb begin
    next_st = st;
    wsel = {st.clock_capture_ctrl[tw_pkg::WSEL_HI_POS +: 2],
            st.output_mode_ctrl[tw_pkg::WSEL_LO_POS +: 2]};
    cls      = modeClass(wsel);
    top      = topOf(wsel, st.compare_value_a, st.capture_value);
    capTop   = topFromCapture(wsel);
    comA     = st.output_mode_ctrl[tw_pkg::CHA_MODE_POS +: 2];
    comB     = st.output_mode_ctrl[tw_pkg::CHB_MODE_POS +: 2];
    clkSel   = st.clock_capture_ctrl[tw_pkg::CLK_SEL_POS +: 3];
    atTop    = (st.count_value == top);
    atBottom = (st.count_value == tw_pkg::CNT_BOTTOM);
    matchA   = (st.count_value == st.compare_value_a);
    matchB   = (st.count_value == st.compare_value_b);
    flagSet  = 4'h0;
    flagClr  = 4'h0;

    next_st.capSync = {st.capSync[0], capture_pin};
    next_st.extSync = {st.extSync[0], external_count_pin};
    next_st.extPrev = st.extSync[1];
    next_st.presc   = st.presc + 10'h001;

    case (clkSel)
      tw_pkg::CS_DIV1:     tick = 1'b1;
      tw_pkg::CS_DIV8:     tick = (st.presc[2:0] == tw_pkg::DIV8_LAST[2:0]);
      tw_pkg::CS_DIV64:    tick = (st.presc[5:0] == tw_pkg::DIV64_LAST[5:0]);
      tw_pkg::CS_DIV256:   tick = (st.presc[7:0] == tw_pkg::DIV256_LAST[7:0]);
      tw_pkg::CS_DIV1024:  tick = (st.presc == tw_pkg::DIV1024_LAST);
      tw_pkg::CS_EXT_FALL: tick = st.extPrev & ~st.extSync[1];
      tw_pkg::CS_EXT_RISE: tick = ~st.extPrev & st.extSync[1];
      default:             tick = 1'b0;
    endcase

    next_st.capHist = {st.capHist[FILTER_LEN-2:0], st.capSync[1]};
    if (st.clock_capture_ctrl[tw_pkg::FILTER_EN_POS]) begin
      if (&st.capHist) begin
        next_st.capFilt = 1'b1;
      end else if (~|st.capHist) begin
        next_st.capFilt = 1'b0;
      end
    end else begin
      next_st.capFilt = st.capSync[1];
    end
    next_st.capPrev = st.capFilt;
    capEdge = st.clock_capture_ctrl[tw_pkg::EDGE_SEL_POS] ? (st.capFilt & ~st.capPrev)
                                                          : (~st.capFilt & st.capPrev);
    if (capEdge && !capTop) begin
      next_st.capture_value = st.count_value;
      flagSet[tw_pkg::FLG_CAPTURE] = 1'b1;
    end

    if (cls == tw_pkg::CLS_NORMAL || cls == tw_pkg::CLS_CTC) begin
      next_st.compare_value_a = st.buffer_a;
      next_st.compare_value_b = st.buffer_b;
    end

    if (tick) begin
      flagSet[tw_pkg::FLG_MATCH_A] = matchA;
      flagSet[tw_pkg::FLG_MATCH_B] = matchB;
      if (capTop && atTop) begin
        flagSet[tw_pkg::FLG_CAPTURE] = 1'b1;
      end
      next_st.waveA = waveNext(cls, comA, 1'b1, wsel, matchA,
                               st.compare_value_a == top, atTop, st.count_down, st.waveA);
      next_st.waveB = waveNext(cls, comB, 1'b0, wsel, matchB,
                               st.compare_value_b == top, atTop, st.count_down, st.waveB);
      case (cls)
        tw_pkg::CLS_PC, tw_pkg::CLS_PFC: begin
          if (!st.count_down) begin
            if (st.count_value >= top) begin
              next_st.count_down  = 1'b1;
              next_st.count_value = st.count_value - 16'h0001;
            end else begin
              next_st.count_value = st.count_value + 16'h0001;
            end
          end else if (atBottom) begin
            next_st.count_down  = 1'b0;
            next_st.count_value = st.count_value + 16'h0001;
          end else begin
            next_st.count_value = st.count_value - 16'h0001;
          end
          if (cls == tw_pkg::CLS_PC && !st.count_down && st.count_value >= top) begin
            next_st.compare_value_a = st.buffer_a;
            next_st.compare_value_b = st.buffer_b;
          end
          if (cls == tw_pkg::CLS_PFC && st.count_down && atBottom) begin
            next_st.compare_value_a = st.buffer_a;
            next_st.compare_value_b = st.buffer_b;
          end
          flagSet[tw_pkg::FLG_OVERFLOW] = st.count_down & atBottom;
        end
        tw_pkg::CLS_FAST: begin
          next_st.count_down  = 1'b0;
          next_st.count_value = atTop ? tw_pkg::CNT_BOTTOM : st.count_value + 16'h0001;
          if (atTop) begin
            next_st.compare_value_a = st.buffer_a;
            next_st.compare_value_b = st.buffer_b;
          end
          flagSet[tw_pkg::FLG_OVERFLOW] = atTop;
        end
        default: begin
          next_st.count_down  = 1'b0;
          next_st.count_value = atTop ? tw_pkg::CNT_BOTTOM : st.count_value + 16'h0001;
          flagSet[tw_pkg::FLG_OVERFLOW] = (st.count_value == tw_pkg::CNT_MAX);
        end
      endcase
    end

    next_st.waveAEn = (comA != 2'b00) & st.pin_direction[0];
    next_st.waveBEn = (comB != 2'b00) & st.pin_direction[1];

    awHs    = s_axi_awvalid & st.awReady;
    wHs     = s_axi_wvalid & st.wReady;
    arHs    = s_axi_arvalid & st.arReady;
    doWrite = st.awHeld & st.wHeld & ~st.bValid;
    wIdx    = st.awAddr[11:2];
    rIdx    = s_axi_araddr[11:2];
    if (awHs) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (wHs) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    if (doWrite) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = tw_pkg::RESP_OKAY;
      case (wIdx)
        tw_pkg::IDX_OUTPUT_MODE_CTRL: if (st.wStrb[0]) begin
          next_st.output_mode_ctrl = st.wData[7:0] & tw_pkg::OUTPUT_MODE_WMASK;
        end
        tw_pkg::IDX_CLOCK_CAPTURE_CTRL: if (st.wStrb[0]) begin
          next_st.clock_capture_ctrl = st.wData[7:0] & tw_pkg::CLOCK_CAPTURE_WMASK;
        end
        tw_pkg::IDX_COUNT_VALUE: begin
          next_st.count_value = merge16(st.count_value, st.wData, st.wStrb);
        end
        tw_pkg::IDX_COMPARE_A: begin
          next_st.buffer_a = merge16(st.buffer_a, st.wData, st.wStrb);
        end
        tw_pkg::IDX_COMPARE_B: begin
          next_st.buffer_b = merge16(st.buffer_b, st.wData, st.wStrb);
        end
        tw_pkg::IDX_CAPTURE: begin
          next_st.capture_value = merge16(st.capture_value, st.wData, st.wStrb);
        end
        tw_pkg::IDX_EVENT_FLAGS: if (st.wStrb[0]) begin
          flagClr = st.wData[3:0];
        end
        tw_pkg::IDX_PIN_DIRECTION: if (st.wStrb[0]) begin
          next_st.pin_direction = st.wData[1:0];
        end
        default: next_st.bResp = tw_pkg::RESP_SLVERR;
      endcase
    end
    // A hardware event in the clearing cycle survives the clear.
    next_st.flags   = (st.flags & ~flagClr) | flagSet;
    next_st.awReady = ~next_st.awHeld;
    next_st.wReady  = ~next_st.wHeld;

    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
    if (arHs) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = tw_pkg::RESP_OKAY;
      case (rIdx)
        tw_pkg::IDX_OUTPUT_MODE_CTRL:   next_st.rData = {24'h000000, st.output_mode_ctrl};
        tw_pkg::IDX_CLOCK_CAPTURE_CTRL: next_st.rData = {24'h000000, st.clock_capture_ctrl};
        tw_pkg::IDX_COUNT_VALUE:        next_st.rData = {16'h0000, st.count_value};
        tw_pkg::IDX_COMPARE_A:          next_st.rData = {16'h0000, st.buffer_a};
        tw_pkg::IDX_COMPARE_B:          next_st.rData = {16'h0000, st.buffer_b};
        tw_pkg::IDX_CAPTURE:            next_st.rData = {16'h0000, st.capture_value};
        tw_pkg::IDX_EVENT_FLAGS:        next_st.rData = {28'h0000000, st.flags};
        tw_pkg::IDX_PIN_DIRECTION:      next_st.rData = {30'h00000000, st.pin_direction};
        default: begin
          next_st.rData = 32'h00000000;
          next_st.rResp = tw_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.arReady = ~next_st.rValid;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awReady;
  assign s_axi_wready  = st.wReady;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;
  assign wave_out_a    = st.waveA;
  assign wave_out_a_en = st.waveAEn;
  assign wave_out_b    = st.waveB;
  assign wave_out_b_en = st.waveBEn;

endmodule : tw_timer16_waveform_control
`default_nettype wire

/* File: verif/tw_timer16_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module tw_timer16_assertions (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       wave_out_a_en,
  input wire logic       wave_out_b_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
    else $error("error read returned data");
  chk_reset_idle: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid
    && !wave_out_a_en && !wave_out_b_en) else $error("outputs active after reset");
  chk_en_quiet: assert property ($fell(reset) |-> !wave_out_a_en [*2])
    else $error("driver enabled right after reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property ($rose(wave_out_a_en));
endmodule : tw_timer16_assertions
bind tw_timer16_waveform_control tw_timer16_assertions u_chk (.*);
`default_nettype wire

/* File: verif/tw_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, wa, wae, wb, wbe;
  logic capPin = 0, extPin = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          n_fail = 0, comparisons = 0, hi;
  always #2 mclk = ~mclk;
  tw_timer16_waveform_control DUT (.mclk(mclk), .reset(reset), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .capture_pin(capPin),
    .external_count_pin(extPin), .wave_out_a(wa), .wave_out_a_en(wae), .wave_out_b(wb),
    .wave_out_b_en(wbe));
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge mclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin r = bresp; break; end
    end
    bready <= 0;
    if (k == 50) begin n_fail++; print_verdict(); end
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int k;
    @(posedge mclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin d = rdata; r = rresp; break; end
    end
    rready <= 0;
    if (k == 50) begin n_fail++; print_verdict(); end
  endtask : rd
  task automatic duty(input logic [7:0] ctl, input logic [7:0] cs, input int lo, input int up);
    wr(12'h204, 0); wr(12'h208, 0); wr(12'h200, ctl); wr(12'h204, cs);
    // The first 256 cycles only bring the output to its steady level.
    repeat (256) @(posedge mclk);
    hi = 0;
    repeat (1024) begin @(posedge mclk); hi += wa; end
    chk(hi >= lo && hi <= up, 1);
  endtask : duty
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 0;
    rd(12'h200); chk(d, 0);
    rd(12'h204); chk(d, 0);
    wr(12'h200, 32'hff); rd(12'h200); chk(d, 32'hf3);
    wr(12'h204, 32'hdf); rd(12'h204); chk(d, 32'hdf);
    wr(12'h204, 0); wr(12'h200, 0); chk(r, tw_pkg::RESP_OKAY);
    rd(12'h3fc); chk(d, 0); chk(r, tw_pkg::RESP_SLVERR);
    wr(12'h3fc, 1); chk(r, tw_pkg::RESP_SLVERR);
    wr(12'h208, 5); repeat (20) @(posedge mclk); rd(12'h208); chk(d, 5);
    wr(12'h20c, 32'h10); wr(12'h21c, 1); wr(12'h208, 0); wr(12'h200, 32'hf0);
    wr(12'h204, 1); repeat (40) @(posedge mclk);
    chk(wa, 1);
    chk(wae, 1);
    chk(wb, 1);
    chk(wbe, 0);
    wr(12'h204, 0); wr(12'h208, 0); wr(12'h200, 32'h80); wr(12'h204, 1);
    repeat (40) @(posedge mclk);
    chk(wa, 0);
    wr(12'h204, 0); wr(12'h208, 0); wr(12'h204, 2); repeat (80) @(posedge mclk);
    rd(12'h208); chk(d >= 9 && d <= 12, 1);
    wr(12'h20c, 32'h40);
    duty(8'h81, 8'h09, 240, 272);
    duty(8'hc1, 8'h09, 752, 784);
    duty(8'h81, 8'h01, 240, 272);
    wr(12'h21c, 0); repeat (2) @(posedge mclk);
    chk(wae, 0);
    wr(12'h204, 32'h01); wr(12'h218, 32'hf); capPin <= 1; repeat (8) @(posedge mclk);
    rd(12'h218); chk(d[3], 0);
    capPin <= 0; repeat (8) @(posedge mclk);
    rd(12'h218); chk(d[3], 1);
    wr(12'h204, 32'h81); wr(12'h218, 32'hf); capPin <= 1; repeat (3) @(posedge mclk);
    capPin <= 0; repeat (10) @(posedge mclk);
    rd(12'h218); chk(d[3], 0);
    capPin <= 1; repeat (10) @(posedge mclk); capPin <= 0; repeat (12) @(posedge mclk);
    rd(12'h218); chk(d[3], 1);
    wr(12'h200, 0); wr(12'h204, 32'h18); wr(12'h218, 32'hf);
    capPin <= 1; repeat (8) @(posedge mclk); capPin <= 0; repeat (8) @(posedge mclk);
    rd(12'h218); chk(d[3], 0);
    wr(12'h204, 32'h07); wr(12'h208, 0);
    repeat (3) begin
      extPin <= 1; repeat (4) @(posedge mclk); extPin <= 0; repeat (4) @(posedge mclk);
    end
    rd(12'h208); chk(d, 3);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
